// File: rtl/vdeact_regs.vh
// Register offsets, field positions and identity values of the virtual deactivate block.
`ifndef VDEACT_REGS_VH
`define VDEACT_REGS_VH

// Byte offsets on the register port.
`define OFS_VIRT_CTRL 12'h000
`define OFS_HYP_CTRL 12'h004
`define OFS_IRQ_STATUS 12'h008
`define OFS_IRQ_CLEAR 12'h00C
`define OFS_IRQ_ENABLE 12'h010
`define OFS_LAST_REQ 12'h014
`define OFS_IDENTITY 12'h020
`define OFS_DEACT_REQ 12'h024
`define OFS_LIST_BASE 12'h040
`define OFS_LIST_LAST 12'h04C

// Deactivate request fields.
`define DEACT_ID_HI 9
`define DEACT_ID_LO 0
`define DEACT_CPU_HI 12
`define DEACT_CPU_LO 10

// List entry fields.
`define LR_VID_HI 9
`define LR_VID_LO 0
`define LR_PID_HI 19
`define LR_PID_LO 10
`define LR_STATE_HI 29
`define LR_STATE_LO 28
`define LR_HW_BIT 31
`define LR_ACTIVE_BIT 29
`define LR_STATE_INVALID 2'h0
`define LR_COUNT 4

// Hypervisor control: counter in bits 31:27.
`define HCR_CNT_HI 31
`define HCR_CNT_LO 27
`define HCR_CNT_W 5

// Virtual control: split-deactivate mode bit.
`define VCTRL_SPLIT_BIT 0

// Interrupt events.
`define EV_UNMATCHED 0
`define EV_FORWARDED 1
`define EV_GROUP0_DROP 2
`define EV_MODE_MISUSE 3
`define EV_COUNT 4

// Identity fields; all values are arbitrary.
`define ID_PRODUCT 12'h5A1
`define ID_ARCH 4'h1
`define ID_REVISION 4'h0
`define ID_IMPLEMENTER 12'h3C7

`endif

// File: rtl/lr_match.v
// Finds the list entry whose virtual ID equals a requested ID.
`timescale 1ns/100ps
`include "vdeact_regs.vh"

module lr_match (
	input wire [32*`LR_COUNT-1:0] entries, // Flattened list entries, entry 0 in the low word.
	input wire [9:0] req_id, // Virtual interrupt ID being deactivated.
	output reg hit, // High when some live entry holds the ID.
	output reg [1:0] hit_index // Lowest matching entry index.
);

	wire [`LR_COUNT-1:0] hit_vec;
	integer k;

	// Invalid entries never match, so a stale ID in a free slot cannot be deactivated.
	genvar g;
	generate
		for (g = 0; g < `LR_COUNT; g = g + 1) begin : per_entry
			assign hit_vec[g] = (entries[32*g+`LR_STATE_HI -: 2] != `LR_STATE_INVALID) &&
				(entries[32*g+`LR_VID_HI -: 10] == req_id);
		end
	endgenerate

	// Lowest index wins; duplicate IDs are a hypervisor error and get a fixed answer.
	always @* begin
		hit = 1'b0;
		hit_index = 2'h0;
		for (k = `LR_COUNT - 1; k >= 0; k = k - 1) begin
			if (hit_vec[k]) begin
				hit = 1'b1;
				hit_index = k[1:0];
			end
		end
	end

endmodule

// File: rtl/event_irq.v
// Sticky event status with enable and write-one-to-clear, driving one level interrupt.
`timescale 1ns/100ps
`include "vdeact_regs.vh"

module event_irq (
	input wire clock, // System clock.
	input wire rstn, // Asynchronous reset, active low.
	input wire ce, // Clock enable; state holds while low.
	input wire [`EV_COUNT-1:0] events, // One-cycle event pulses.
	input wire clear_wr, // Write strobe of the clear register.
	input wire enable_wr, // Write strobe of the enable register.
	input wire [`EV_COUNT-1:0] wdata, // Write data bits.
	output reg [`EV_COUNT-1:0] status_q, // Sticky status.
	output reg [`EV_COUNT-1:0] enable_q, // Interrupt enables.
	output wire irq // Level interrupt.
);

	// A new event beats a clear in the same cycle so it is never lost.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			status_q <= 4'h0;
			enable_q <= 4'h0;
		end else if (ce) begin
			status_q <= (status_q & ~({`EV_COUNT{clear_wr}} & wdata)) | events;
			if (enable_wr) begin
				enable_q <= wdata;
			end
		end
	end

	// The interrupt follows status and enable with no extra delay.
	assign irq = |(status_q & enable_q);

endmodule

// File: rtl/virt_deactivate.v
// Virtual deactivate block: register port, list entries, unmatched counter and distributor forwarding.
`timescale 1ns/100ps
`include "vdeact_regs.vh"

module virt_deactivate (
	input wire clock, // System clock, 125 MHz.
	input wire rstn, // Asynchronous reset, active low.
	input wire ce, // Clock enable; all state holds while low.
	input wire [11:0] addr, // Register byte address.
	input wire [31:0] wdata, // Register write data.
	input wire wr, // Write strobe, one cycle.
	input wire rd, // Read strobe, one cycle.
	output reg [31:0] rdata, // Read data, valid the cycle after rd.
	output wire phys_deact_valid, // Deactivate request to the distributor, one-cycle pulse.
	output reg [9:0] phys_deact_id, // Physical ID of the forwarded deactivate.
	input wire phys_group0, // Distributor: the interrupt on phys_deact_id is Group 0.
	output wire irq // Level interrupt from enabled status bits.
);

	// Register decode strobes.
	wire sel_vctrl = (addr == `OFS_VIRT_CTRL);
	wire sel_hcr = (addr == `OFS_HYP_CTRL);
	wire sel_status = (addr == `OFS_IRQ_STATUS);
	wire sel_clear = (addr == `OFS_IRQ_CLEAR);
	wire sel_enable = (addr == `OFS_IRQ_ENABLE);
	wire sel_last = (addr == `OFS_LAST_REQ);
	wire sel_ident = (addr == `OFS_IDENTITY);
	wire sel_deact = (addr == `OFS_DEACT_REQ);
	wire sel_list = (addr >= `OFS_LIST_BASE) && (addr <= `OFS_LIST_LAST) && (addr[1:0] == 2'h0);
	wire [1:0] list_sel_index = addr[3:2];

	// Control and state registers.
	reg split_mode_q;
	reg [`HCR_CNT_W-1:0] unmatched_cnt_q;
	reg [`HCR_CNT_W-1:0] unmatched_cnt_d;
	reg [31:0] list_q [0:`LR_COUNT-1];
	reg fwd_pend_q;
	reg [9:0] last_id_q;
	reg [2:0] last_cpu_q;
	reg last_hit_q;
	reg [1:0] last_index_q;
	reg [`EV_COUNT-1:0] events_d;

	wire [`EV_COUNT-1:0] status_q;
	wire [`EV_COUNT-1:0] enable_q;

	// Request fields; bits 31:13 are never looked at.
	wire [9:0] req_id = wdata[`DEACT_ID_HI:`DEACT_ID_LO];
	wire [2:0] req_cpu = wdata[`DEACT_CPU_HI:`DEACT_CPU_LO];

	wire deact_wr = wr && sel_deact;
	// Only a write in split-deactivate mode acts on the list entries.
	wire deact_valid = deact_wr && split_mode_q;
	wire deact_misuse = deact_wr && !split_mode_q;

	// Flattened list entries for the matcher.
	wire [32*`LR_COUNT-1:0] entries_flat;
	genvar g;
	generate
		for (g = 0; g < `LR_COUNT; g = g + 1) begin : flat
			assign entries_flat[32*g+31 -: 32] = list_q[g];
		end
	endgenerate

	wire hit;
	wire [1:0] hit_index;

	// The matcher looks at the ID and the entry state only, so Group 0 and Group 1 share one path.
	lr_match u_match (
		.entries(entries_flat),
		.req_id(req_id),
		.hit(hit),
		.hit_index(hit_index)
	);

	wire [31:0] hit_entry = list_q[hit_index];
	wire hit_active = hit_entry[`LR_ACTIVE_BIT];
	wire hit_hw = hit_entry[`LR_HW_BIT];

	// Virtual control register holds the split-deactivate mode bit.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			split_mode_q <= 1'b0;
		end else if (ce) begin
			if (wr && sel_vctrl) begin
				split_mode_q <= wdata[`VCTRL_SPLIT_BIT];
			end
		end
	end

	// Counter next value; an unmatched deactivate adds one on top of a same-cycle software write.
	always @* begin
		unmatched_cnt_d = unmatched_cnt_q;
		if (wr && sel_hcr) begin
			unmatched_cnt_d = wdata[`HCR_CNT_HI:`HCR_CNT_LO];
		end
		if (deact_valid && !hit) begin
			unmatched_cnt_d = unmatched_cnt_d + 5'h01;
		end
	end

	// The counter wraps; software owning the hypervisor side must drain it before overflow.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			unmatched_cnt_q <= 5'h00;
		end else if (ce) begin
			unmatched_cnt_q <= unmatched_cnt_d;
		end
	end

	// List entries: software writes whole words; a deactivate clears only the active bit of the hit.
	integer i;
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (i = 0; i < `LR_COUNT; i = i + 1) begin
				list_q[i] <= 32'h00000000;
			end
		end else if (ce) begin
			if (wr && sel_list) begin
				list_q[list_sel_index] <= wdata;
			end else if (deact_valid && hit && hit_active) begin
				// Active goes to invalid, active-and-pending goes to pending.
				list_q[hit_index][`LR_ACTIVE_BIT] <= 1'b0;
			end
		end
	end

	// Entries that are only pending are left untouched; software must not aim at them.

	// Forward register: the distributor sees the physical ID the cycle after the write.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fwd_pend_q <= 1'b0;
			phys_deact_id <= 10'h000;
		end else if (ce) begin
			fwd_pend_q <= deact_valid && hit && hit_active && hit_hw;
			if (deact_valid && hit && hit_hw) begin
				phys_deact_id <= hit_entry[`LR_PID_HI:`LR_PID_LO];
			end
		end
	end

	// The distributor answers the Group 0 query on the same clock, so the drop is decided in one cycle.
	assign phys_deact_valid = ce && fwd_pend_q && !phys_group0;

	// Last request record, readable for the hypervisor when it emulates deactivates.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			last_id_q <= 10'h000;
			last_cpu_q <= 3'h0;
			last_hit_q <= 1'b0;
			last_index_q <= 2'h0;
		end else if (ce) begin
			if (deact_valid) begin
				last_id_q <= req_id;
				last_cpu_q <= req_cpu;
				last_hit_q <= hit;
				last_index_q <= hit_index;
			end
		end
	end

	// Event pulses for the status register.
	always @* begin
		events_d = 4'h0;
		events_d[`EV_UNMATCHED] = deact_valid && !hit;
		events_d[`EV_FORWARDED] = ce && fwd_pend_q && !phys_group0;
		events_d[`EV_GROUP0_DROP] = ce && fwd_pend_q && phys_group0;
		events_d[`EV_MODE_MISUSE] = deact_misuse;
	end

	event_irq u_events (
		.clock(clock),
		.rstn(rstn),
		.ce(ce),
		.events(events_d),
		.clear_wr(wr && sel_clear),
		.enable_wr(wr && sel_enable),
		.wdata(wdata[`EV_COUNT-1:0]),
		.status_q(status_q),
		.enable_q(enable_q),
		.irq(irq)
	);

	// Read data register; write-only and unmapped addresses read zero, identity ignores writes.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata <= 32'h00000000;
		end else if (ce) begin
			if (!rd) begin
				rdata <= 32'h00000000;
			end else if (sel_vctrl) begin
				rdata <= {31'h00000000, split_mode_q};
			end else if (sel_hcr) begin
				rdata <= {unmatched_cnt_q, 27'h0000000};
			end else if (sel_status) begin
				rdata <= {28'h0000000, status_q};
			end else if (sel_enable) begin
				rdata <= {28'h0000000, enable_q};
			end else if (sel_last) begin
				rdata <= {16'h0000, last_hit_q, last_index_q, last_cpu_q, last_id_q};
			end else if (sel_ident) begin
				rdata <= {`ID_PRODUCT, `ID_ARCH, `ID_REVISION, `ID_IMPLEMENTER};
			end else if (sel_list) begin
				rdata <= list_q[list_sel_index];
			end else begin
				rdata <= 32'h00000000;
			end
		end
	end

endmodule

// File: tb/virt_deactivate_monitor.sv
// Concurrent checks on the ports of the virtual deactivate block.
`timescale 1ns/100ps
`include "vdeact_regs.vh"
module virt_deactivate_monitor (
	input wire clock, // System clock.
	input wire rstn, // Asynchronous reset, active low.
	input wire ce, // Clock enable.
	input wire [11:0] addr, // Register address.
	input wire [31:0] wdata, // Register write data.
	input wire wr, // Write strobe.
	input wire rd, // Read strobe.
	input wire [31:0] rdata, // Read data.
	input wire phys_deact_valid, // Forwarded deactivate pulse.
	input wire [9:0] phys_deact_id, // Forwarded physical ID.
	input wire phys_group0, // Group 0 flag from the distributor.
	input wire irq // Level interrupt.
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// Read data stand only in the cycle after a read while clock enable stays high, so a stale word never looks like a fresh one.
	AST_RDATA_IDLE: assert property (!(rd && ce) |=> rdata == 32'h0)
		else $error("read data not zero outside a read");
	AST_IDENTITY: assert property (rd && ce && addr == `OFS_IDENTITY |=> rdata == {`ID_PRODUCT, `ID_ARCH, `ID_REVISION, `ID_IMPLEMENTER})
		else $error("identity word wrong");
	AST_DEACT_WO: assert property (rd && ce && addr == `OFS_DEACT_REQ |=> rdata == 32'h0)
		else $error("deactivate register read not zero");
	AST_UNMAPPED: assert property (rd && ce && addr == 12'h018 |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	// A forward after a cycle with clock enable high is caused by a deactivate write in that cycle.
	AST_VALID_CAUSE: assert property (phys_deact_valid && $past(ce) |-> $past(wr && ce && addr == `OFS_DEACT_REQ))
		else $error("forward without a deactivate write");
	AST_ID_STABLE: assert property (!$past(wr && ce && addr == `OFS_DEACT_REQ) |-> $stable(phys_deact_id))
		else $error("physical ID changed without a deactivate");
	AST_GROUP0: assert property (phys_group0 |-> !phys_deact_valid)
		else $error("forward sent to a Group 0 interrupt");
	AST_IRQ_MASKED: assert property (wr && ce && addr == `OFS_IRQ_ENABLE && wdata[3:0] == 4'h0 |=> !irq)
		else $error("interrupt high with all enables off");
	// Main scenarios seen.
	COV_FWD: cover property (phys_deact_valid);
	COV_IRQ: cover property (irq);
	COV_RSVD: cover property (wr && addr == `OFS_DEACT_REQ && wdata[31:13] != 19'h0);
endmodule
bind virt_deactivate virt_deactivate_monitor u_mon (.clock(clock), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .phys_deact_valid(phys_deact_valid), .phys_deact_id(phys_deact_id),
	.phys_group0(phys_group0), .irq(irq));

// File: tb/dist_model.sv
// Model of the physical distributor that receives forwarded deactivates.
`timescale 1ns/100ps
module dist_model (
	input wire clock, // System clock.
	input wire phys_deact_valid, // Forwarded deactivate pulse.
	input wire [9:0] phys_deact_id, // Physical ID of the request.
	output wire phys_group0 // High when that ID is Group 0.
);
	logic [9:0] got[$];
	// IDs with bit 9 set are Group 0 here, so the bench reaches both groups by choice of ID.
	assign phys_group0 = phys_deact_id[9];
	// Every request that arrives is logged for the bench to compare.
	always @(posedge clock) begin
		if (phys_deact_valid) begin
			got.push_back(phys_deact_id);
		end
	end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the virtual deactivate block with a reference model.
`timescale 1ns/100ps
`include "vdeact_regs.vh"
module testbench;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ce = 1'b1;
	wire [31:0] rdata;
	wire phys_deact_valid;
	wire [9:0] phys_deact_id;
	wire phys_group0;
	wire irq;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [31:0] lr_m[4];
	logic [3:0] st_m = 4'h0;
	logic [4:0] cnt_m = 5'h0;
	logic [9:0] fwd_m[$];
	virt_deactivate u_virt_deactivate (.clock(clock), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .phys_deact_valid(phys_deact_valid), .phys_deact_id(phys_deact_id),
		.phys_group0(phys_group0), .irq(irq));
	dist_model u_dist_model (.clock(clock), .phys_deact_valid(phys_deact_valid), .phys_deact_id(phys_deact_id),
		.phys_group0(phys_group0));
	// Clock of 8 ns and a cycle ceiling that cuts a hang short.
	always #4 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 4000) begin
			fails++;
			end_of_test;
		end
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	// Data are looked at mid-cycle, in the one cycle they stand.
	task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		chk(name, exp, rdata);
	endtask
	// Reference step for one deactivate; clearing the active bit maps active to invalid and both to pending.
	task automatic deact(input logic [9:0] id);
		logic [31:0] d;
		int hit;
		logic [31:0] last_m;
		d = ($urandom() & 32'hFFFF_FC00) | {22'h0, id};
		hit = -1;
		for (int i = 3; i >= 0; i--) if (lr_m[i][29:28] != 2'h0 && lr_m[i][9:0] == id) hit = i;
		// The last request record keeps hit, entry index (0 on a miss), source CPU and ID.
		last_m = {16'h0, hit >= 0, (hit >= 0) ? 2'(hit) : 2'h0, d[12:10], id};
		if (hit < 0) begin
			cnt_m++;
			st_m[0] = 1'b1;
		end else if (lr_m[hit][29]) begin
			lr_m[hit][29] = 1'b0;
			if (lr_m[hit][31] && lr_m[hit][19]) st_m[2] = 1'b1;
			if (lr_m[hit][31] && !lr_m[hit][19]) begin
				fwd_m.push_back(lr_m[hit][19:10]);
				st_m[1] = 1'b1;
			end
		end
		wr_reg(`OFS_DEACT_REQ, d);
		repeat (2) @(posedge clock);
		chk("forwards", fwd_m.size(), u_dist_model.got.size());
		if (fwd_m.size() > 0 && u_dist_model.got.size() > 0)
			chk("fwd id", {22'h0, fwd_m.pop_front()}, {22'h0, u_dist_model.got.pop_front()});
		for (int i = 0; i < 4; i++) rd_chk("list entry", 12'(`OFS_LIST_BASE + 4 * i), lr_m[i]);
		rd_chk("counter", `OFS_HYP_CTRL, {cnt_m, 27'h0});
		rd_chk("status", `OFS_IRQ_STATUS, {28'h0, st_m});
		rd_chk("last request", `OFS_LAST_REQ, last_m);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence.
	initial begin
		int seed;
		int ord[4];
		logic [1:0] st;
		seed = $urandom(22);
		ord = '{3, 1, 0, 2};
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		rd_chk("identity", `OFS_IDENTITY, {`ID_PRODUCT, `ID_ARCH, `ID_REVISION, `ID_IMPLEMENTER});
		wr_reg(`OFS_IDENTITY, 32'hFFFF_FFFF);
		rd_chk("identity rewrite", `OFS_IDENTITY, {`ID_PRODUCT, `ID_ARCH, `ID_REVISION, `ID_IMPLEMENTER});
		rd_chk("deact read", `OFS_DEACT_REQ, 32'h0);
		rd_chk("unmapped", 12'h018, 32'h0);
		$display("test identity done");
		// Split mode on before any deactivate; entry 3 holds a Group 0 physical ID, entry 2 is not hardware-backed.
		wr_reg(`OFS_VIRT_CTRL, 32'h1);
		for (int i = 0; i < 4; i++) begin
			st = (i == 0) ? 2'h2 : 2'h2 | 2'($urandom() & 1);
			lr_m[i] = {i != 2, 1'b0, st, 8'h0, i == 3, 9'($urandom()), 2'(i), 8'($urandom())};
			wr_reg(12'(`OFS_LIST_BASE + 4 * i), lr_m[i]);
		end
		// Every entry is aimed at once while it is still active, never while it is only pending.
		foreach (ord[k]) deact(lr_m[ord[k]][9:0]);
		$display("test deactivate done");
		// Entry 0 is now invalid, so its ID plays the single active interrupt kept outside the list entries.
		deact(lr_m[0][9:0]);
		deact(lr_m[0][9:0]);
		$display("test unmatched done");
		wr_reg(`OFS_IRQ_ENABLE, 32'h1);
		@(negedge clock);
		chk("irq on", 32'h1, {31'h0, irq});
		wr_reg(`OFS_IRQ_CLEAR, 32'h1);
		st_m[0] = 1'b0;
		@(negedge clock);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr_reg(`OFS_IRQ_ENABLE, 32'h0);
		wr_reg(`OFS_IRQ_CLEAR, 32'hF);
		rd_chk("status clear", `OFS_IRQ_STATUS, 32'h0);
		$display("test interrupt done");
		// A deactivate strobe under a low clock enable must leave the counter where it was.
		@(posedge clock);
		ce <= 1'b0;
		wr_reg(`OFS_DEACT_REQ, {22'h0, lr_m[0][9:0]});
		ce <= 1'b1;
		rd_chk("counter frozen", `OFS_HYP_CTRL, {cnt_m, 27'h0});
		$display("test clock enable done");
		end_of_test;
	end
endmodule
